// File: src/ddrct_bank_engine.sv
// Eight-bank row state, auto-precharge lockout, refresh and read launch
// Function
// RULE1: Controller may send read/write with auto-precharge before minimum row-active time.
// RULE2: Device delays its internal precharge until minimum row-active time is met.
// RULE3: Controller waits precharge period; precharge-all adds one average clock period.
// RULE4: At most four activations per four-activate window, activate spacing still applies. Code: neither window nor activate spacing is tracked.
// RULE5: Precharge after read spaced by additive latency plus half burst unless longer.
// RULE6: Read captures four-beat prefetch; data appears one CAS latency later. Code: first beat additive plus CAS latency plus one clock later.
// RULE7: Write completion equals write recovery clocks plus precharge period, rounded up.
// RULE8: Controller issues 8192 refreshes per 64ms commercial or 32ms industrial.
// RULE9: Refreshes may come back to back; no maximum refresh interval is enforced.
// RULE10: Clock enable held steady across three consecutive rising edges after transition.
// RULE11: On reset, clock keeps running setup plus one clock plus hold after enable low.
// RULE12: Nanosecond requirements convert to clocks using the average clock period.
// RULE13: Controller should drive strobe valid no later than the write command edge.
// RULE14: Each strobe belongs to its own nibble or byte; x16 has lower and upper.
// RULE15: Controller keeps down-counters per constraint and blocks commands until expired. Code: row and auto-precharge counters only; nothing is blocked.
`timescale 1ns/100ps
`default_nettype none
module ddrct_bank_engine
  import ddrct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire ddrct_pkg::ddrct_cmd_type cmd,
  input wire logic [ddrct_pkg::CFG_W-1:0] cas_latency,
  input wire logic [ddrct_pkg::CFG_W-1:0] additive_latency,
  input wire logic [ddrct_pkg::CFG_W-1:0] write_recovery_clocks,
  input wire ddrct_pkg::ddrct_width_type width_mode,
  input wire logic [ddrct_pkg::FETCH_W-1:0] fetch_data,
  output logic [ddrct_pkg::BANKS-1:0] bank_open,
  output logic [ddrct_pkg::BANKS-1:0] internal_precharge,
  output logic refresh_done,
  output logic [ddrct_pkg::REF_ROW_W-1:0] refresh_row,
  output ddrct_pkg::ddrct_dq_type dq_out,
  output logic read_busy
);
  import ddrct_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic open;
    logic ap_pending;
    logic [CNT_W-1:0] ras_cnt;
    logic [CNT_W-1:0] ap_cnt;
  } ddrct_bank_type;

  typedef struct packed {
    ddrct_bank_type [BANKS-1:0] bank;
    logic [BANKS-1:0] precharge_pulse;
    logic refresh_pulse;
    logic [REF_ROW_W-1:0] refresh_row;
  } ddrct_engine_type;

  ddrct_engine_type state;
  ddrct_engine_type next_state;
  logic read_start;
  logic [LAT_W-1:0] read_latency;

  function automatic logic [BANKS-1:0] bank_onehot(input logic [BANK_W-1:0] b);
    bank_onehot = '0;
    bank_onehot[b] = 1'b1;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [BANKS-1:0] sel;
    logic [CNT_W-1:0] wr_done;
    next_state = state;
    next_state.precharge_pulse = '0;
    next_state.refresh_pulse = 1'b0;
    sel = bank_onehot(cmd.bank);
    // RULE7: write recovery before precharge
    wr_done = CNT_W'(additive_latency) + CNT_W'(cas_latency) - CNT_ONE + BURST_HALF
      + CNT_W'(write_recovery_clocks);
    for (int i = 0; i < BANKS; i++) begin
      if (state.bank[i].ras_cnt != CNT_ZERO) begin
        next_state.bank[i].ras_cnt = state.bank[i].ras_cnt - CNT_ONE;
      end
      if (state.bank[i].ap_cnt != CNT_ZERO) begin
        next_state.bank[i].ap_cnt = state.bank[i].ap_cnt - CNT_ONE;
      end
      // RULE2: lockout until row time met
      if (state.bank[i].ap_pending && state.bank[i].ras_cnt == CNT_ZERO
          && state.bank[i].ap_cnt == CNT_ZERO) begin
        next_state.bank[i].ap_pending = 1'b0;
        next_state.bank[i].open = 1'b0;
        next_state.precharge_pulse[i] = 1'b1;
      end
      if (cmd.valid && sel[i]) begin
        case (cmd.code)
          DDRCT_ACTIVATE: begin
            next_state.bank[i].open = 1'b1;
            next_state.bank[i].ap_pending = 1'b0;
            next_state.bank[i].ras_cnt = RAS_LOAD;
            // Reopened bank drops the closing pulse
            next_state.precharge_pulse[i] = 1'b0;
          end
          DDRCT_READ: begin
            // RULE1: early auto-precharge accepted
            // RULE5: additive latency plus half burst
            if (cmd.auto_precharge) begin
              next_state.bank[i].ap_pending = 1'b1;
              next_state.bank[i].ap_cnt = CNT_W'(additive_latency) + BURST_HALF;
            end
          end
          DDRCT_WRITE: begin
            if (cmd.auto_precharge) begin
              next_state.bank[i].ap_pending = 1'b1;
              next_state.bank[i].ap_cnt = wr_done;
            end
          end
          DDRCT_PRECHARGE: begin
            next_state.bank[i].open = 1'b0;
            next_state.bank[i].ap_pending = 1'b0;
          end
          default: begin
          end
        endcase
      end
      if (cmd.valid && cmd.code == DDRCT_PRECHARGE_ALL) begin
        next_state.bank[i].open = 1'b0;
        next_state.bank[i].ap_pending = 1'b0;
      end
    end
    // RULE9: back-to-back refresh accepted
    // No upper refresh interval is tracked; bursts are legal
    if (cmd.valid && cmd.code == DDRCT_REFRESH) begin
      next_state.refresh_pulse = 1'b1;
      next_state.refresh_row = state.refresh_row + REF_ROW_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Read launch
  // ----------------------------------------
  // RULE6: read latency from command
  assign read_start = cmd.valid && (cmd.code == DDRCT_READ);
  assign read_latency = LAT_W'(additive_latency) + LAT_W'(cas_latency);

  ddrct_read_pipe u_read_pipe (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(read_start),
    .latency(read_latency),
    .fetch_data(fetch_data),
    .width_mode(width_mode),
    .dq_out(dq_out),
    .busy(read_busy)
  );

  always_comb begin
    for (int i = 0; i < BANKS; i++) begin
      bank_open[i] = state.bank[i].open;
    end
  end

  assign internal_precharge = state.precharge_pulse;
  assign refresh_done = state.refresh_pulse;
  assign refresh_row = state.refresh_row;

endmodule // ddrct_bank_engine
`default_nettype wire

// File: src/ddrct_pkg.sv
// Shared constants and carrier types for the DDR2 bank timing engine
package ddrct_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int BANKS = 8;
  localparam int BANK_W = 3;
  localparam int CNT_W = 5;
  localparam int LAT_W = 4;
  localparam int CFG_W = 3;
  localparam int BEAT_W = 16;
  localparam int PREFETCH_BEATS = 4;
  localparam int FETCH_W = BEAT_W * PREFETCH_BEATS;
  localparam int REF_ROW_W = 13;
  localparam int BEAT_IDX_W = 2;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int ROW_ACTIVE_MIN_TIME_NS = 40;
  // Least time, rounded up to whole clocks
  localparam int ROW_ACTIVE_MIN_CYCLES =
    (ROW_ACTIVE_MIN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] RAS_LOAD = CNT_W'(ROW_ACTIVE_MIN_CYCLES);
  localparam logic [CNT_W-1:0] BURST_HALF = CNT_W'(PREFETCH_BEATS / 2);
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [LAT_W-1:0] LAT_ONE = 4'h1;
  localparam logic [LAT_W-1:0] LAT_ZERO = 4'h0;
  localparam logic [REF_ROW_W-1:0] REF_ROW_ONE = 13'h0001;
  localparam logic [BEAT_IDX_W-1:0] BEAT_LAST = 2'h3;

  // ----------------------------------------
  // Commands and modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    DDRCT_NOP = 3'h0,
    DDRCT_ACTIVATE = 3'h1,
    DDRCT_READ = 3'h2,
    DDRCT_WRITE = 3'h3,
    DDRCT_PRECHARGE = 3'h4,
    DDRCT_PRECHARGE_ALL = 3'h5,
    DDRCT_REFRESH = 3'h6
  } ddrct_cmd_code_type;

  typedef enum logic [1:0] {
    DDRCT_X4 = 2'h0,
    DDRCT_X8 = 2'h1,
    DDRCT_X16 = 2'h2
  } ddrct_width_type;

  typedef struct packed {
    logic valid;
    ddrct_cmd_code_type code;
    logic [BANK_W-1:0] bank;
    logic auto_precharge;
  } ddrct_cmd_type;

  typedef struct packed {
    logic [BEAT_W-1:0] dq;
    logic [BEAT_W-1:0] dq_oe;
    logic lower_strobe;
    logic lower_strobe_oe;
    logic upper_strobe;
    logic upper_strobe_oe;
  } ddrct_dq_type;

endpackage

// File: src/ddrct_read_pipe.sv
// Read prefetch capture, latency delay and beat output with strobe lanes
`timescale 1ns/100ps
`default_nettype none
module ddrct_read_pipe
  import ddrct_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [ddrct_pkg::LAT_W-1:0] latency,
  input wire logic [ddrct_pkg::FETCH_W-1:0] fetch_data,
  input wire ddrct_pkg::ddrct_width_type width_mode,
  output ddrct_pkg::ddrct_dq_type dq_out,
  output logic busy
);
  import ddrct_pkg::*;

  typedef enum logic [1:0] {
    RP_IDLE = 2'b00,
    RP_WAIT = 2'b01,
    RP_BURST = 2'b11
  } ddrct_rp_state_type;

  typedef struct packed {
    ddrct_rp_state_type fsm;
    logic [LAT_W-1:0] cnt;
    logic [BEAT_IDX_W-1:0] beat;
    logic [FETCH_W-1:0] fetch;
    ddrct_dq_type out;
  } ddrct_rp_type;

  ddrct_rp_type state;
  ddrct_rp_type next_state;

  // ----------------------------------------
  // Lane masks
  // ----------------------------------------
  function automatic logic [BEAT_W-1:0] lane_mask(input ddrct_width_type w);
    case (w)
      DDRCT_X4: lane_mask = 16'h000f;
      DDRCT_X8: lane_mask = 16'h00ff;
      default: lane_mask = 16'hffff;
    endcase
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.out.dq_oe = '0;
    next_state.out.lower_strobe_oe = 1'b0;
    next_state.out.upper_strobe_oe = 1'b0;
    next_state.out.lower_strobe = 1'b0;
    next_state.out.upper_strobe = 1'b0;
    case (state.fsm)
      RP_WAIT: begin
        if (state.cnt == LAT_ZERO) begin
          next_state.fsm = RP_BURST;
          next_state.beat = '0;
        end else begin
          next_state.cnt = state.cnt - LAT_ONE;
        end
      end
      RP_BURST: begin
        // RULE14: strobe per lane
        next_state.out.dq = state.fetch[BEAT_W-1:0] & lane_mask(width_mode);
        next_state.out.dq_oe = lane_mask(width_mode);
        next_state.out.lower_strobe = ~state.beat[0];
        next_state.out.lower_strobe_oe = 1'b1;
        next_state.out.upper_strobe = ~state.beat[0];
        next_state.out.upper_strobe_oe = (width_mode == DDRCT_X16);
        next_state.fetch = {{BEAT_W{1'b0}}, state.fetch[FETCH_W-1:BEAT_W]};
        next_state.beat = state.beat + 2'h1;
        if (state.beat == BEAT_LAST) begin
          next_state.fsm = RP_IDLE;
        end
      end
      default: begin
        next_state.fsm = RP_IDLE;
      end
    endcase
    // RULE6: prefetch then latency
    // A new read restarts the pipe; the scheduler keeps reads apart
    if (start) begin
      next_state.fetch = fetch_data;
      next_state.fsm = RP_WAIT;
      next_state.cnt = (latency == LAT_ZERO) ? LAT_ZERO : latency - LAT_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dq_out = state.out;
  assign busy = (state.fsm != RP_IDLE);

endmodule // ddrct_read_pipe
`default_nettype wire

// File: tb/ddrct_bank_engine_chk.sv
// Port assertions for the bank timing engine
`timescale 1ns/100ps
`default_nettype none
module ddrct_bank_engine_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire ddrct_pkg::ddrct_cmd_type cmd,
  input wire logic [ddrct_pkg::CFG_W-1:0] cas_latency,
  input wire logic [ddrct_pkg::CFG_W-1:0] additive_latency,
  input wire ddrct_pkg::ddrct_width_type width_mode,
  input wire logic [ddrct_pkg::BANKS-1:0] bank_open,
  input wire logic [ddrct_pkg::BANKS-1:0] internal_precharge,
  input wire logic refresh_done,
  input wire logic [ddrct_pkg::REF_ROW_W-1:0] refresh_row,
  input wire ddrct_pkg::ddrct_dq_type dq_out
);
  import ddrct_pkg::*;
  typedef struct packed {
    logic [BANKS-1:0][4:0] age;
    logic [4:0] rd_age;
    logic [4:0] rd_lat;
    logic rd_seen;
  } ddrct_chk_state_type;
  ddrct_chk_state_type st;
  ddrct_chk_state_type next_st;
  logic [BANKS-1:0] ras_ok;
  // Latency captured at the read, so later changes do not shift the window
  always_comb begin
    next_st = st;
    for (int b = 0; b < BANKS; b++) begin
      if (st.age[b] != 5'h1f) next_st.age[b] = st.age[b] + 5'h01;
      ras_ok[b] = st.age[b] >= 5'(ROW_ACTIVE_MIN_CYCLES);
    end
    if (st.rd_age != 5'h1f) next_st.rd_age = st.rd_age + 5'h01;
    if (cmd.valid && cmd.code == DDRCT_ACTIVATE) next_st.age[cmd.bank] = 5'h00;
    if (cmd.valid && cmd.code == DDRCT_READ) begin
      next_st.rd_age = 5'h00;
      next_st.rd_lat = 5'(additive_latency) + 5'(cas_latency);
      next_st.rd_seen = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) st <= '0;
    else st <= next_st;
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_act; cmd.valid && cmd.code == DDRCT_ACTIVATE; endsequence
  sequence s_ref; cmd.valid && cmd.code == DDRCT_REFRESH; endsequence
  sequence s_beat; dq_out.lower_strobe_oe; endsequence
  AST_ACT_OPENS: assert property (s_act |=> bank_open[$past(cmd.bank)])
    else $error("activate left bank closed");
  AST_PRE_ALL: assert property (cmd.valid && cmd.code == DDRCT_PRECHARGE_ALL |=> bank_open == '0)
    else $error("precharge all left a bank open");
  AST_RAS_LOCKOUT: assert property ((internal_precharge & ~ras_ok) == '0)
    else $error("internal precharge before row active time");
  AST_AP_CLOSES: assert property (internal_precharge != '0 |-> (internal_precharge & ~$past(bank_open)) == '0 && (bank_open & internal_precharge) == '0)
    else $error("internal precharge on wrong bank");
  AST_REF_STEP: assert property (s_ref |=> refresh_done && refresh_row == $past(refresh_row) + 13'h0001)
    else $error("refresh did not advance");
  AST_REF_CAUSE: assert property (refresh_done |-> $past(cmd.valid) && $past(cmd.code) == DDRCT_REFRESH)
    else $error("refresh done without refresh");
  AST_RD_WINDOW: assert property (s_beat |-> st.rd_seen && st.rd_age > st.rd_lat && st.rd_age <= st.rd_lat + 5'h04)
    else $error("read beat outside latency window");
  AST_RD_BURST: assert property (st.rd_seen && st.rd_age == st.rd_lat + 5'h01 |-> s_beat ##1 s_beat ##1 s_beat ##1 s_beat)
    else $error("read burst not four beats");
  AST_LANES: assert property (s_beat |-> dq_out.upper_strobe_oe == (width_mode == DDRCT_X16) && dq_out.dq_oe == (width_mode == DDRCT_X4 ? 16'h000f : width_mode == DDRCT_X8 ? 16'h00ff : 16'hffff))
    else $error("lanes do not match width");
  AST_STROBE: assert property (s_beat |-> dq_out.lower_strobe == (st.rd_age[0] ^ st.rd_lat[0]))
    else $error("strobe phase wrong");
endmodule // ddrct_bank_engine_chk
bind ddrct_bank_engine ddrct_bank_engine_chk ddrct_bank_engine_chk_inst (.ref_clk(ref_clk), .reset(reset), .cmd(cmd),
  .cas_latency(cas_latency), .additive_latency(additive_latency), .width_mode(width_mode), .bank_open(bank_open),
  .internal_precharge(internal_precharge), .refresh_done(refresh_done), .refresh_row(refresh_row), .dq_out(dq_out));
`default_nettype wire

// File: tb/ddrct_bank_engine_tb_top.sv
// Self-checking bench for the bank timing engine
`timescale 1ns/100ps
`default_nettype none
module ddrct_bank_engine_tb_top;
  import ddrct_pkg::*;
  logic ref_clk, reset, refresh_done, read_busy;
  logic [CFG_W-1:0] cas_latency, additive_latency, write_recovery_clocks;
  ddrct_width_type width_mode;
  logic [FETCH_W-1:0] fetch_data;
  ddrct_cmd_type cmd;
  logic [BANKS-1:0] bank_open, internal_precharge;
  logic [REF_ROW_W-1:0] refresh_row;
  ddrct_dq_type dq_out;
  logic [BANK_W-1:0] b;
  int miscompares, checked, cycles, n;
  integer seed = 32'h897b;
  ddrct_ctrl_model ddrct_ctrl_model_inst (.ref_clk(ref_clk), .cmd(cmd));
  ddrct_bank_engine ddrct_bank_engine_inst (.ref_clk(ref_clk), .reset(reset), .cmd(cmd), .cas_latency(cas_latency),
    .additive_latency(additive_latency), .write_recovery_clocks(write_recovery_clocks), .width_mode(width_mode),
    .fetch_data(fetch_data), .bank_open(bank_open), .internal_precharge(internal_precharge),
    .refresh_done(refresh_done), .refresh_row(refresh_row), .dq_out(dq_out), .read_busy(read_busy));
  // ----------------------------------------
  // Clock, limit and helpers
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Run is under ten thousand cycles; the limit only catches a hang
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [15:0] lane_mask(input ddrct_width_type w);
    return w == DDRCT_X4 ? 16'h000f : w == DDRCT_X8 ? 16'h00ff : 16'hffff;
  endfunction
  // Auto-precharge spacing after the column command, in clocks
  function automatic int ap_clocks(input logic wr, input int al, input int cl, input int rec);
    return wr ? al + cl - 1 + PREFETCH_BEATS / 2 + rec : al + PREFETCH_BEATS / 2;
  endfunction
  initial begin
    reset = 1'b1;
    cas_latency = 3'h3;
    additive_latency = 3'h0;
    write_recovery_clocks = 3'h2;
    width_mode = DDRCT_X16;
    fetch_data = '0;
    // reset held, clock running
    // Reset spans more than three registrations; the clock never stops
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 1'b0;
    check(16'(bank_open), 16'h0000);
    check(16'(refresh_row), 16'h0000);
    for (int k = 0; k < 4; k++) begin
      b = k == 0 ? 3'h7 : 3'($random(seed));
      write_recovery_clocks = 3'($random(seed) & 3);
      ddrct_ctrl_model_inst.issue(DDRCT_ACTIVATE, b, 1'b0);
      ddrct_ctrl_model_inst.issue(k[0] ? DDRCT_WRITE : DDRCT_READ, b, 1'b1);
      ddrct_ctrl_model_inst.idle();
      n = 2;
      while (internal_precharge[b] !== 1'b1 && n < 40) begin
        @(negedge ref_clk);
        n++;
      end
      check(16'(n >= 12 && n <= 13), 16'h0001);
      check(16'(bank_open[b]), 16'h0000);
      @(negedge ref_clk);
      check(16'(internal_precharge), 16'h0000);
    end
    // spacing once row time is met
    for (int k = 0; k < 2; k++) begin
      additive_latency = 3'($random(seed) & 3);
      ddrct_ctrl_model_inst.issue(DDRCT_ACTIVATE, 3'h2, 1'b0);
      repeat (ROW_ACTIVE_MIN_CYCLES) ddrct_ctrl_model_inst.idle();
      ddrct_ctrl_model_inst.issue(k[0] ? DDRCT_WRITE : DDRCT_READ, 3'h2, 1'b1);
      ddrct_ctrl_model_inst.idle();
      n = 1;
      while (internal_precharge[2] !== 1'b1 && n < 40) begin
        @(negedge ref_clk);
        n++;
      end
      check(16'(n), 16'(ap_clocks(k[0], additive_latency, cas_latency, write_recovery_clocks) + 2));
    end
    ddrct_ctrl_model_inst.issue(DDRCT_ACTIVATE, 3'h1, 1'b0);
    ddrct_ctrl_model_inst.issue(DDRCT_ACTIVATE, 3'h6, 1'b0);
    ddrct_ctrl_model_inst.issue(DDRCT_PRECHARGE, 3'h1, 1'b0);
    check(16'(bank_open), 16'h0042);
    ddrct_ctrl_model_inst.issue(DDRCT_PRECHARGE_ALL, 3'h0, 1'b0);
    check(16'(bank_open), 16'h0040);
    ddrct_ctrl_model_inst.settle_precharge(1'b1);
    check(16'(bank_open), 16'h0000);
    $display("test row timing done");
    n = 1 + ($random(seed) & 31);
    repeat (n) ddrct_ctrl_model_inst.issue(DDRCT_REFRESH, 3'h0, 1'b0);
    ddrct_ctrl_model_inst.idle();
    check(16'(refresh_row), 16'(n));
    check(16'(refresh_done), 16'h0001);
    @(negedge ref_clk);
    check(16'(refresh_done), 16'h0000);
    repeat (8192 - n) ddrct_ctrl_model_inst.issue(DDRCT_REFRESH, 3'h0, 1'b0);
    ddrct_ctrl_model_inst.idle();
    check(16'(refresh_row), 16'h0000);
    $display("test refresh done");
    for (int t = 0; t < 6; t++) begin
      width_mode = ddrct_width_type'(t % 3);
      cas_latency = 3'h2 + 3'($random(seed) & 3);
      additive_latency = 3'($random(seed) & 3);
      fetch_data = {$random(seed), $random(seed)};
      ddrct_ctrl_model_inst.issue(DDRCT_READ, 3'h0, 1'b0);
      ddrct_ctrl_model_inst.idle();
      check(16'(read_busy), 16'h0001);
      repeat (additive_latency + cas_latency + 1) @(negedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        check(dq_out.dq, fetch_data[16*i +: 16] & lane_mask(width_mode));
        check(dq_out.dq_oe, lane_mask(width_mode));
        check(16'({dq_out.lower_strobe_oe, dq_out.upper_strobe_oe, dq_out.lower_strobe,
          dq_out.upper_strobe & dq_out.upper_strobe_oe}),
          16'({1'b1, width_mode == DDRCT_X16, ~i[0], width_mode == DDRCT_X16 && !i[0]}));
        @(negedge ref_clk);
      end
      check(16'(dq_out.lower_strobe_oe), 16'h0000);
      check(16'(read_busy), 16'h0000);
    end
    $display("test read path done");
    complete_run();
  end
endmodule // ddrct_bank_engine_tb_top
`default_nettype wire

// File: tb/ddrct_ctrl_model.sv
// Controller-side command driver for the bank timing engine
`timescale 1ns/100ps
`default_nettype none
module ddrct_ctrl_model (
  input wire logic ref_clk,
  output ddrct_pkg::ddrct_cmd_type cmd
);
  import ddrct_pkg::*;
  // ----------------------------------------
  // Command issue
  // ----------------------------------------
  initial cmd = '0;
  // early and back-to-back
  // No spacing kept here, so the engine sees the harshest order
  task automatic issue(input ddrct_cmd_code_type code, input logic [BANK_W-1:0] bank, input logic ap);
    @(negedge ref_clk);
    cmd = '{valid: 1'b1, code: code, bank: bank, auto_precharge: ap};
  endtask
  task automatic idle();
    @(negedge ref_clk);
    cmd = '0;
  endtask
  // ----------------------------------------
  // Spacing keeper
  // ----------------------------------------
  // Plain defaults, not taken from any speed grade
  localparam int PRECHARGE_PERIOD_NS = 15;
  localparam int AVG_CLK_PS = 4000;
  function automatic int to_clocks(input int ns);
    return (ns * 1000 + AVG_CLK_PS - 1) / AVG_CLK_PS;
  endfunction
  // precharge wait counted down
  // Precharge-all costs one clock more, whatever was open
  // levels settle half a clock before the edge
  task automatic settle_precharge(input logic all_banks);
    int left;
    left = to_clocks(PRECHARGE_PERIOD_NS) + int'(all_banks);
    while (left > 0) begin
      idle();
      left--;
    end
  endtask
endmodule // ddrct_ctrl_model
`default_nettype wire
